/* File: common/csl_pkg.sv */
// shared constants and carriers for the chip-select and lane-strobe unit
package csl_pkg;
    localparam int NUM_SEL = 8;
    localparam int ADDR_W = 7;
    // register map: select n at n*0x10, three words each
    localparam logic [1:0] KIND_BASE = 2'h0;
    localparam logic [1:0] KIND_MASK = 2'h1;
    localparam logic [1:0] KIND_CTRL = 2'h2;
    // mask register fields
    localparam int MASK_VALID_BIT = 0;
    localparam int MASK_LO = 16;
    // control register fields
    localparam int CTRL_W = 14;
    localparam int CTRL_BWR = 3;
    localparam int CTRL_BRD = 4;
    localparam int CTRL_BEM = 5;
    localparam int CTRL_PS_LO = 6;
    localparam int CTRL_AA = 8;
    localparam int CTRL_WS_LO = 10;
    localparam logic [CTRL_W-1:0] CTRL_RST = 14'h0000;
    localparam logic [15:0] BASE_RST = 16'h0000;
    localparam logic [15:0] MASK_RST = 16'h0000;
    // port width codes, same encoding as the boot straps
    localparam logic [1:0] PS_32 = 2'h0;
    localparam logic [1:0] PS_8 = 2'h1;
    // boot wait states when auto-acknowledge strap is high
    localparam logic [3:0] BOOT_WS = 4'hF;
    // transfer sizes
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;
    localparam logic [1:0] SZ_LINE = 2'h3;

    typedef enum logic {CSL_IDLE, CSL_BUSY} csl_state_e;

    // one bus cycle request from the core or an external master
    typedef struct packed {
        logic [31:0] addr;
        logic [1:0] size;
        logic read;
        logic ext_master;
    } csl_req_s;

    // strobe outputs toward the memories
    typedef struct packed {
        logic [7:0] select_n;
        logic [3:0] lane_strobes_n;
    } csl_pins_s;
endpackage

/* File: rtl/csl_unit.sv */
// chip-select decoder, read strobe and lane strobe generator
//
// Operation
// R1: eight programmable select outputs, seven down to zero
// R2: masked match covers 64K to 4G blocks
// R3: per-select base, mask, width, burst, waits, termination
// R4: after reset only select 0 active, global
// R5: boot config from data pins at reset release
// R6: read strobe changes on falling clock edges only
// R7: read strobe only when a select matches
// R8: mode bit picks byte or write enables
// R9: lane strobes from size, address, width, burst; the lanes here ignore burst
// R10: strobe 0 gates top byte, low active
// R11: 8-bit port: only strobe 0 low
// R12: 16-bit byte: strobe 0 or 1 by A0
// R13: 32-bit byte: one strobe by A1..A0
// R14: 16-bit wider transfers: strobes 0,1 low
// R15: 32-bit word by A1; longer all four
// R16: external master cycles decoded too
// R17: boot select for all until valid set
// R18: auto-ack strap: off, or 15 waits
// R19: width straps: 00=32, 01=8, 1x=16
// R20: multi-match: all driven, external, 32-bit, no burst
// R21: outputs low active, negated in reset/unclaimed
// R22: select held for whole cycle incl. waits
`timescale 1ns/1ps
module csl_unit (
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clk_en,
    // register port
    input wire logic [csl_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // bus cycle from the core or external master
    input wire logic cyc_start,
    input wire csl_pkg::csl_req_s cyc_req,
    input wire logic ext_ack_in,
    // boot straps on data pins 7..5
    input wire logic [2:0] boot_straps,
    // memory side
    output csl_pkg::csl_pins_s mem_pins,
    output logic read_strobe_n,
    // cycle status
    output logic cyc_ack,
    output logic cyc_ext_term,
    output logic cyc_burst_ok,
    output logic cyc_wide32
);
    // reset release through two flops
    logic rst_meta_r;
    logic rst_n_s;
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_meta_r <= 1'b0;
            rst_n_s <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n_s <= rst_meta_r;
        end
    end

    // straps cross in through two flops
    logic [2:0] strap_meta_r;
    logic [2:0] strap_sync_r;
    logic boot_loaded_r;
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            strap_meta_r <= 3'h0;
            strap_sync_r <= 3'h0;
        end
        else
        begin
            strap_meta_r <= boot_straps;
            strap_sync_r <= strap_meta_r;
        end
    end

    // boot control word built from the held strap levels
    wire strap_aa = strap_sync_r[2];
    wire [1:0] strap_ps = strap_sync_r[1:0]; // R19
    wire [csl_pkg::CTRL_W-1:0] boot_ctrl;
    // byte-enable mode on, bursts off: the boot part is unknown, so play safe
    assign boot_ctrl = {(strap_aa ? csl_pkg::BOOT_WS : 4'h0), 1'b0, strap_aa, strap_ps, 1'b1, 5'h00}; // R5 R18

    // programming registers, one set per select
    logic [15:0] base_r [csl_pkg::NUM_SEL];
    logic [15:0] mask_r [csl_pkg::NUM_SEL];
    logic [csl_pkg::NUM_SEL-1:0] valid_r;
    logic [csl_pkg::CTRL_W-1:0] ctrl_r [csl_pkg::NUM_SEL];

    // register decode
    wire [2:0] reg_sel = reg_addr[6:4];
    wire [1:0] reg_kind = reg_addr[3:2];
    wire wr_base = reg_wr && reg_kind == csl_pkg::KIND_BASE;
    wire wr_mask = reg_wr && reg_kind == csl_pkg::KIND_MASK;
    wire wr_ctrl = reg_wr && reg_kind == csl_pkg::KIND_CTRL;
    wire [31:0] rd_mux;
    assign rd_mux = (reg_kind == csl_pkg::KIND_BASE) ? {base_r[reg_sel], 16'h0000} :
                    (reg_kind == csl_pkg::KIND_MASK) ? {mask_r[reg_sel], 15'h0000, valid_r[reg_sel]} :
                    (reg_kind == csl_pkg::KIND_CTRL) ? {18'h00000, ctrl_r[reg_sel]} : 32'h00000000;

    // register writes; select 0 control takes the straps once after release
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < csl_pkg::NUM_SEL; i++)
            begin
                base_r[i] <= csl_pkg::BASE_RST;
                mask_r[i] <= csl_pkg::MASK_RST;
                ctrl_r[i] <= csl_pkg::CTRL_RST;
            end
            valid_r <= 8'h00;
            boot_loaded_r <= 1'b0;
        end
        else if (clk_en && rst_n_s)
        begin
            boot_loaded_r <= 1'b1;
            if (!boot_loaded_r)
                ctrl_r[0] <= boot_ctrl; // R5
            else if (wr_ctrl)
                ctrl_r[reg_sel] <= reg_wdata[csl_pkg::CTRL_W-1:0]; // R3
            if (wr_base)
                base_r[reg_sel] <= reg_wdata[31:16];
            if (wr_mask)
            begin
                mask_r[reg_sel] <= reg_wdata[31:16];
                valid_r[reg_sel] <= reg_wdata[csl_pkg::MASK_VALID_BIT];
            end
        end
    end

    // read data stands one cycle after the strobe
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            reg_rdata <= 32'h00000000;
        else if (clk_en)
            reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
    end

    // address match per select; masked bits ignore the upper address
    wire boot_mode = !valid_r[0];
    logic [csl_pkg::NUM_SEL-1:0] hit;
    always_comb
    begin
        for (int i = 0; i < csl_pkg::NUM_SEL; i++)
            hit[i] = valid_r[i] && !boot_mode &&
                     (((cyc_req.addr[31:16] ^ base_r[i]) & ~mask_r[i]) == 16'h0000); // R1 R2 R16
        if (boot_mode)
            hit = 8'h01; // R4 R17
    end

    // single-hit configuration lookup
    wire multi_hit = (hit & (hit - 8'h01)) != 8'h00;
    logic [csl_pkg::CTRL_W-1:0] hit_ctrl;
    always_comb
    begin
        hit_ctrl = csl_pkg::CTRL_RST;
        for (int i = 0; i < csl_pkg::NUM_SEL; i++)
            if (hit[i])
                hit_ctrl = ctrl_r[i];
    end

    // effective attributes; several hits fall back to a plain 32-bit cycle
    wire [1:0] eff_ps = multi_hit ? csl_pkg::PS_32 : hit_ctrl[csl_pkg::CTRL_PS_LO +: 2]; // R20
    wire eff_aa = !multi_hit && hit_ctrl[csl_pkg::CTRL_AA]; // R20 R3
    wire [3:0] eff_ws = hit_ctrl[csl_pkg::CTRL_WS_LO +: 4];
    wire eff_burst = !multi_hit &&
                     (cyc_req.read ? hit_ctrl[csl_pkg::CTRL_BRD] : hit_ctrl[csl_pkg::CTRL_BWR]); // R20 R9
    wire eff_bem = hit_ctrl[csl_pkg::CTRL_BEM];

    // active lanes, bit 0 gates data 31..24
    logic [3:0] lanes_act;
    always_comb
    begin
        if (eff_ps == csl_pkg::PS_8)
            lanes_act = 4'h1; // R11
        else if (eff_ps == csl_pkg::PS_32)
        begin
            if (cyc_req.size == csl_pkg::SZ_BYTE)
                lanes_act = 4'(4'h1 << cyc_req.addr[1:0]); // R13
            else if (cyc_req.size == csl_pkg::SZ_WORD)
                lanes_act = cyc_req.addr[1] ? 4'hC : 4'h3; // R15
            else
                lanes_act = 4'hF; // R15
        end
        else
        begin
            if (cyc_req.size == csl_pkg::SZ_BYTE)
                lanes_act = cyc_req.addr[0] ? 4'h2 : 4'h1; // R12
            else
                lanes_act = 4'h3; // R14
        end
    end

    // write-enable mode keeps lanes quiet on reads
    wire lanes_on = eff_bem || !cyc_req.read; // R8
    wire [3:0] lanes_n_nxt = lanes_on ? ~lanes_act : 4'hF; // R9 R10

    // cycle sequencer
    csl_pkg::csl_state_e state_r;
    logic [3:0] wait_r;
    logic int_term_r;
    logic rd_en_r;
    wire claim = cyc_start && hit != 8'h00;
    wire int_done = int_term_r && wait_r == 4'h0;
    wire ext_done = !int_term_r && ext_ack_in;
    wire cyc_end = state_r == csl_pkg::CSL_BUSY && (int_done || ext_done);

    // outputs come from flops; selects, lanes and status stand for the whole cycle, cyc_ack pulses after it only for internally terminated cycles
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_r <= csl_pkg::CSL_IDLE;
            wait_r <= 4'h0;
            int_term_r <= 1'b0;
            rd_en_r <= 1'b0;
            mem_pins <= '1; // R21
            cyc_ack <= 1'b0;
            cyc_ext_term <= 1'b0;
            cyc_burst_ok <= 1'b0;
            cyc_wide32 <= 1'b0;
        end
        else if (clk_en && rst_n_s && boot_loaded_r)
        begin
            cyc_ack <= 1'b0;
            unique case (state_r)
                csl_pkg::CSL_IDLE:
                begin
                    if (claim)
                    begin
                        state_r <= csl_pkg::CSL_BUSY;
                        wait_r <= eff_aa ? eff_ws : 4'h0;
                        int_term_r <= eff_aa;
                        rd_en_r <= cyc_req.read; // R7
                        mem_pins.select_n <= ~hit; // R20 R22
                        mem_pins.lane_strobes_n <= lanes_n_nxt;
                        cyc_ext_term <= !eff_aa;
                        cyc_burst_ok <= eff_burst;
                        cyc_wide32 <= eff_ps == csl_pkg::PS_32;
                    end
                end
                csl_pkg::CSL_BUSY:
                begin
                    if (wait_r != 4'h0)
                        wait_r <= wait_r - 4'h1; // R22
                    if (cyc_end)
                    begin
                        state_r <= csl_pkg::CSL_IDLE;
                        rd_en_r <= 1'b0;
                        mem_pins <= '1; // R21 R22
                        cyc_ack <= int_done;
                        cyc_ext_term <= 1'b0;
                        cyc_burst_ok <= 1'b0;
                        cyc_wide32 <= 1'b0;
                    end
                end
            endcase
        end
    end

    // read strobe retimed to the falling edge, half a cycle after selects
    always_ff @(negedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            read_strobe_n <= 1'b1; // R21
        else if (clk_en)
            read_strobe_n <= !rd_en_r; // R6 R7
    end
endmodule

/* File: tb/csl_mem_model.sv */
// far-side memory model: strap levels and external cycle termination
`timescale 1ns/1ps
module csl_mem_model (
    // clock
    input wire logic sys_clk,
    // bench settings
    input wire logic [2:0] strap_lvl,
    input wire logic [3:0] ack_dly,
    // unit pins
    input wire logic [7:0] select_n,
    input wire logic cyc_ext_term,
    output logic ext_ack_in,
    output logic [2:0] boot_straps
);
    logic [3:0] cnt;
    // straps stay put across reset release
    assign boot_straps = strap_lvl;
    initial
    begin
        cnt = 4'h0;
        ext_ack_in = 1'b0;
    end
    // wait ack_dly cycles, then a one-cycle ack
    always @(posedge sys_clk)
    begin
        if (select_n == 8'hFF || !cyc_ext_term || ext_ack_in)
        begin
            cnt <= 4'h0;
            ext_ack_in <= 1'b0;
        end
        else if (cnt == ack_dly)
            ext_ack_in <= 1'b1;
        else
            cnt <= cnt + 4'h1;
    end
endmodule

/* File: tb/csl_unit_checker.sv */
// pin-level assertions for the select and strobe outputs
`timescale 1ns/1ps
module csl_unit_checker (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // termination and status
    input wire logic ext_ack_in,
    input wire logic cyc_ack,
    input wire logic cyc_ext_term,
    input wire logic cyc_burst_ok,
    input wire logic cyc_wide32,
    // memory side
    input wire csl_pkg::csl_pins_s mem_pins,
    input wire logic read_strobe_n
);
    logic rs_rise_r;
    // strobe level at rising edges; a change there shows at the next fall
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            rs_rise_r <= 1'b1;
        else
            rs_rise_r <= read_strobe_n;
    end
    sequence s_sel_on;
        mem_pins.select_n != 8'hFF;
    endsequence
    sequence s_ext_done;
        cyc_ext_term && ext_ack_in;
    endsequence
    a_strobe_fall_edge: assert property (@(negedge sys_clk) disable iff (!nrst)
        read_strobe_n == rs_rise_r) else $error("read strobe moved on rising edge");
    a_strobe_needs_sel: assert property (@(posedge sys_clk) disable iff (!nrst)
        $fell(read_strobe_n) |-> s_sel_on) else $error("read strobe without select");
    a_reset_negated: assert property (@(posedge sys_clk)
        !nrst |-> mem_pins == 12'hFFF && read_strobe_n && !cyc_ack) else $error("pins active in reset");
    a_lanes_need_sel: assert property (@(posedge sys_clk) disable iff (!nrst)
        mem_pins.lane_strobes_n != 4'hF |-> s_sel_on) else $error("lanes without select");
    a_multi_ext_32: assert property (@(posedge sys_clk) disable iff (!nrst)
        $countones(~mem_pins.select_n) > 1 |-> cyc_ext_term && cyc_wide32 && !cyc_burst_ok)
        else $error("multi match not external 32-bit");
    a_sel_holds: assert property (@(posedge sys_clk) disable iff (!nrst)
        s_sel_on ##0 !(cyc_ext_term && ext_ack_in) |=> mem_pins.select_n == $past(mem_pins.select_n) || cyc_ack)
        else $error("select dropped mid cycle");
    a_ext_end_neg: assert property (@(posedge sys_clk) disable iff (!nrst)
        s_sel_on ##0 s_ext_done |=> mem_pins == 12'hFFF) else $error("pins held after ext ack");
    a_ack_pulse: assert property (@(posedge sys_clk) disable iff (!nrst)
        cyc_ack |-> !cyc_ext_term ##1 !cyc_ack) else $error("bad internal ack");
endmodule
bind csl_unit csl_unit_checker u_chk (.sys_clk(sys_clk), .nrst(nrst), .ext_ack_in(ext_ack_in), .cyc_ack(cyc_ack),
    .cyc_ext_term(cyc_ext_term), .cyc_burst_ok(cyc_burst_ok), .cyc_wide32(cyc_wide32), .mem_pins(mem_pins),
    .read_strobe_n(read_strobe_n));

/* File: tb/testbench.sv */
// self-checking bench for the chip-select and lane-strobe unit
`timescale 1ns/1ps
module testbench;
    logic sys_clk, nrst, clk_en, reg_wr, reg_rd, cyc_start, ext_ack_in, read_strobe_n;
    logic cyc_ack, cyc_ext_term, cyc_burst_ok, cyc_wide32;
    logic [6:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [2:0] boot_straps, strap_lvl;
    logic [3:0] ack_dly;
    csl_pkg::csl_req_s cyc_req;
    csl_pkg::csl_pins_s mem_pins;
    int num_errors, n_checks, n, nb;
    logic [3:0] st;
    // 40 MHz
    always #12.5 sys_clk = ~sys_clk;
    csl_unit DUT (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cyc_start(cyc_start), .cyc_req(cyc_req),
        .ext_ack_in(ext_ack_in), .boot_straps(boot_straps), .mem_pins(mem_pins), .read_strobe_n(read_strobe_n),
        .cyc_ack(cyc_ack), .cyc_ext_term(cyc_ext_term), .cyc_burst_ok(cyc_burst_ok), .cyc_wide32(cyc_wide32));
    csl_mem_model u_mem (.sys_clk(sys_clk), .strap_lvl(strap_lvl), .ack_dly(ack_dly), .select_n(mem_pins.select_n),
        .cyc_ext_term(cyc_ext_term), .ext_ack_in(ext_ack_in), .boot_straps(boot_straps));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic wr(input logic [6:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        chk(reg_rdata, e);
    endtask
    // one bus cycle; e is {select_n, lanes}; n counts cycles with a select low
    // st holds {ack at end, ext_term, burst_ok, wide32} for the caller to compare
    task automatic cyc(input logic [31:0] a, input logic [1:0] sz, input logic r, input logic [11:0] e);
        @(posedge sys_clk);
        cyc_start <= 1'b1;
        cyc_req <= '{a, sz, r, a[29]};
        @(posedge sys_clk);
        cyc_start <= 1'b0;
        @(negedge sys_clk);
        #1;
        chk({mem_pins, read_strobe_n}, {e, ~r | &e[11:4]});
        st = {1'b0, cyc_ext_term, cyc_burst_ok, cyc_wide32};
        n = 0;
        while (mem_pins.select_n != 8'hFF && n < 40)
        begin
            n++;
            @(negedge sys_clk);
        end
        st[3] = cyc_ack;
        chk(n < 40, 1);
    endtask
    // expected lanes, bit i low when lane i is active
    function automatic logic [3:0] lx(input logic [1:0] s, input logic [1:0] a, input logic [1:0] p);
        if (p == csl_pkg::PS_8)
            return 4'hE;
        if (p[1])
            return s != csl_pkg::SZ_BYTE ? 4'hC : (a[0] ? 4'hD : 4'hE);
        if (s == csl_pkg::SZ_BYTE)
            return ~(4'h1 << a);
        return s == csl_pkg::SZ_WORD ? (a[1] ? 4'h3 : 4'hC) : 4'h0;
    endfunction
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        num_errors++;
        finish_test();
    end
    initial
    begin
        {sys_clk, reg_wr, reg_rd, cyc_start, reg_addr, reg_wdata, cyc_req} = '0;
        nrst = 1'b1;
        clk_en = 1'b1;
        strap_lvl = 3'h6;
        ack_dly = 4'h3;
        // fall after time zero so the asynchronous reset edge is never missed
        #1;
        nrst = 1'b0;
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rd(7'h14, 32'h0);
        rd(7'h0C, 32'h0);
        cyc(32'h8000_0001, csl_pkg::SZ_BYTE, 1'b1, 12'hFED);
        chk(st, 4'h8);
        nb = n;
        cyc(32'h0000_0002, csl_pkg::SZ_WORD, 1'b0, 12'hFEC);
        wr(7'h00, 32'h1000_FFFF);
        rd(7'h00, 32'h1000_0000);
        wr(7'h04, 32'h0000_0001);
        for (int p = 0; p < 3; p++)
        begin
            wr(7'h08, 32'h120 | (32'(p) << 6));
            for (int s = 0; s < 4; s++)
                for (int a = 0; a < 4; a++)
                    cyc({30'h0400_0000, 2'(a) & (s == 0 ? 2'h3 : 2'h2)}, 2'(s), 1'(a),
                        {8'hFE, lx(2'(s), 2'(a) & (s == 0 ? 2'h3 : 2'h2), 2'(p))});
        end
        chk(nb - n, 15);
        wr(7'h08, 32'h118);
        cyc(32'h1000_0000, csl_pkg::SZ_LONG, 1'b1, 12'hFEF);
        chk(st, 4'hB);
        cyc(32'h1000_0000, csl_pkg::SZ_LONG, 1'b0, 12'hFE0);
        cyc(32'h3000_0000, csl_pkg::SZ_LONG, 1'b1, 12'hFFF);
        chk(st, 4'h0);
        wr(7'h10, 32'h2000_0000);
        wr(7'h14, 32'h00FF_FFFF);
        rd(7'h14, 32'h00FF_0001);
        wr(7'h18, 32'h20);
        cyc(32'h20AB_0000, csl_pkg::SZ_BYTE, 1'b1, 12'hFDE);
        chk(n > 4, 1);
        chk(st, 4'h5);
        wr(7'h20, 32'h2000_0000);
        wr(7'h24, 32'h00FF_0001);
        wr(7'h28, 32'h178);
        ack_dly <= 4'h0;
        cyc(32'h2000_0002, csl_pkg::SZ_BYTE, 1'b1, 12'hF9B);
        chk(st, 4'h5);
        finish_test();
    end
endmodule
